// ---- include/mcrp_cfg.svh ----
// constants for the mac configuration, clock and reset front end
`ifndef MCRP_CFG_SVH
`define MCRP_CFG_SVH
`define MCRP_ADDR_W_AVB      17
`define MCRP_ADDR_W_NOAVB    12
`define MCRP_VEC_W           80
`define MCRP_SPD_HI          66
`define MCRP_SPD_LO          65
`define MCRP_SPD_1G          2'h2
`define MCRP_SPD_100         2'h1
`define MCRP_SPD_10          2'h0
`define MCRP_SPD_RST         2'h2
`define MCRP_REF_KHZ         125000
`define MCRP_RATE_1G_KHZ     125000
`define MCRP_RATE_100_KHZ    25000
`define MCRP_RATE_10_KHZ     2500
`define MCRP_DIV_1G          (`MCRP_REF_KHZ / `MCRP_RATE_1G_KHZ)
`define MCRP_DIV_100         (`MCRP_REF_KHZ / `MCRP_RATE_100_KHZ)
`define MCRP_DIV_10          (`MCRP_REF_KHZ / `MCRP_RATE_10_KHZ)
`define MCRP_RESP_OKAY       2'h0
`endif

// ---- include/mcrp_pkg.sv ----
// types shared by the mac configuration, clock and reset front end
package mcrp_pkg;
    typedef struct packed {
        logic [79:0] rx_cfg;
        logic [79:0] tx_cfg;
        logic [1:0]  speed;
        logic [5:0]  div_cnt;
        logic        tx_clk_en;
        logic        rx_rst_o;
        logic        tx_rst_o;
        logic        bvalid;
        logic        rvalid;
        logic [31:0] rdata;
        logic        wr_pulse;
        logic [16:0] wr_addr;
        logic [31:0] wr_data;
    } mcrp_state_t;
endpackage : mcrp_pkg

// ---- rtl/mcrp_front.sv ----
// configuration vector, speed, transmit clock enable, reset and bus front end
`timescale 1ns/1ns
`include "mcrp_cfg.svh"
// Rules for this block and its surroundings
// R1: bus address is 17 bits with the bridging endpoint, otherwise 12 bits.
// R2: bus handshakes run on the bus clock and idle under the local bus reset.
// R3: without management port, receive settings come from the 80-bit receive vector.
// R4: without management port, transmit settings come from the 80-bit transmit vector.
// R5: every vector bit is registered on entry, so it may change at any time.
// R6: the global reset input, low, resets the whole block asynchronously.
// R7: receive and transmit reset inputs each reset only their own domain.
// R8: active-high receive and transmit reset outputs follow software reset requests.
// R9: transmit clock rate is 125 MHz at 1G, 25 MHz at 100M, 2.5 MHz at 10M.
// R10: the surrounding design supplies a free-running 125 MHz reference clock.
// R11: client transmit logic is clocked from the transmit clock output.
// R12: speed flags follow the two-bit speed field from register or vector.
// R13: with the management port present, both vectors are ignored.
module mcrp_front
    import mcrp_pkg::*;
#(
    parameter bit AVB_EN       = 1'b0,
    parameter bit MGMT_PRESENT = 1'b1,
    parameter int ADDR_W       = AVB_EN ? `MCRP_ADDR_W_AVB : `MCRP_ADDR_W_NOAVB // R1
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              rx_rst_n,
    input  wire logic              tx_rst_n,
    input  wire logic              s_axi_resetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   reg_wr,
    output logic [ADDR_W-1:0]      reg_waddr,
    output logic [31:0]            reg_wdata,
    output logic [ADDR_W-1:0]      reg_raddr,
    input  wire logic [31:0]       reg_rdata,
    input  wire logic [1:0]        mgmt_speed,
    input  wire logic [79:0]       mgmt_rx_cfg,
    input  wire logic [79:0]       mgmt_tx_cfg,
    input  wire logic [79:0]       rx_mac_config_vector,
    input  wire logic [79:0]       tx_mac_config_vector,
    input  wire logic              sw_rx_reset_req,
    input  wire logic              sw_tx_reset_req,
    output logic [79:0]            rx_cfg_out,
    output logic [79:0]            tx_cfg_out,
    output logic                   rx_reset,
    output logic                   tx_reset,
    output logic                   tx_clk_en,
    output logic                   speed_100_flag,
    output logic                   speed_low_flag
);
    localparam logic [5:0] DIV_1G  = 6'(`MCRP_DIV_1G);
    localparam logic [5:0] DIV_100 = 6'(`MCRP_DIV_100);
    localparam logic [5:0] DIV_10  = 6'(`MCRP_DIV_10);

    logic        rst_meta_reg;
    logic        core_rst_n;
    mcrp_state_t st_reg;
    mcrp_state_t st_next;
    logic        wr_go;
    logic        rd_go;
    logic [1:0]  spd_sel;
    logic [5:0]  div_lim;

    // two-stage release of the global reset; assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0; // R6
            core_rst_n   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            core_rst_n   <= rst_meta_reg;
        end
    end

    // write taken only with address and data together, read when no answer is pending
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid && s_axi_resetn; // R2
    assign rd_go         = s_axi_arvalid && !st_reg.rvalid && s_axi_resetn; // R2
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign reg_raddr     = s_axi_araddr; // read data sampled in the accepting cycle

    // speed source: management contents win over the vector when the port exists
    assign spd_sel = MGMT_PRESENT ? mgmt_speed
                                  : st_reg.tx_cfg[`MCRP_SPD_HI:`MCRP_SPD_LO]; // R12 R13

    // divide ratio against the 125 MHz reference rate
    always_comb begin
        case (st_reg.speed)
            `MCRP_SPD_1G:  div_lim = DIV_1G;
            `MCRP_SPD_100: div_lim = DIV_100;
            default:       div_lim = DIV_10;
        endcase
    end

    // next state of the whole block
    always_comb begin
        st_next          = st_reg;
        st_next.wr_pulse = 1'b0;
        // vectors are flopped on entry so they may be driven asynchronously
        st_next.rx_cfg = MGMT_PRESENT ? mgmt_rx_cfg : rx_mac_config_vector; // R3 R5 R13
        st_next.tx_cfg = MGMT_PRESENT ? mgmt_tx_cfg : tx_mac_config_vector; // R4 R5 R13
        st_next.rx_rst_o = sw_rx_reset_req; // R8
        st_next.tx_rst_o = sw_tx_reset_req; // R8
        st_next.speed    = spd_sel; // R12
        // a speed change restarts the divider, so the enable fires in that same cycle
        if (spd_sel != st_reg.speed || st_reg.div_cnt >= div_lim - 6'h01) begin
            st_next.div_cnt = 6'h00; // R9
        end else begin
            st_next.div_cnt = st_reg.div_cnt + 6'h01;
        end
        st_next.tx_clk_en = (st_next.div_cnt == 6'h00); // R9
        // bus answers hold until the master takes them
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (wr_go) begin
            st_next.bvalid   = 1'b1; // R2
            st_next.wr_pulse = 1'b1;
            st_next.wr_addr  = 17'(s_axi_awaddr);
            st_next.wr_data  = s_axi_wdata;
        end
        if (rd_go) begin
            st_next.rvalid = 1'b1; // R2
            st_next.rdata  = reg_rdata;
        end
        // local domain resets touch only their own state
        if (!s_axi_resetn) begin
            st_next.bvalid   = 1'b0; // R2
            st_next.rvalid   = 1'b0;
            st_next.wr_pulse = 1'b0;
        end
        if (!rx_rst_n) begin
            st_next.rx_cfg = '0; // R7
        end
        if (!tx_rst_n) begin
            st_next.tx_cfg    = '0; // R7
            st_next.speed     = `MCRP_SPD_RST;
            st_next.div_cnt   = 6'h00;
            st_next.tx_clk_en = 1'b0;
        end
    end

    // single state register, cleared by the global reset (speed loaded with the 1G code) regardless of other inputs
    always_ff @(posedge mclk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            st_reg       <= '0; // R6
            st_reg.speed <= `MCRP_SPD_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs from flops, responses tied to OKAY, speed flags decoded from the speed flop
    assign s_axi_bvalid   = st_reg.bvalid;
    assign s_axi_bresp    = `MCRP_RESP_OKAY;
    assign s_axi_rvalid   = st_reg.rvalid;
    assign s_axi_rdata    = st_reg.rdata;
    assign s_axi_rresp    = `MCRP_RESP_OKAY;
    assign reg_wr         = st_reg.wr_pulse;
    assign reg_waddr      = ADDR_W'(st_reg.wr_addr);
    assign reg_wdata      = st_reg.wr_data;
    assign rx_cfg_out     = st_reg.rx_cfg;
    assign tx_cfg_out     = st_reg.tx_cfg;
    assign rx_reset       = st_reg.rx_rst_o;
    assign tx_reset       = st_reg.tx_rst_o;
    assign tx_clk_en      = st_reg.tx_clk_en;
    assign speed_100_flag = (st_reg.speed == `MCRP_SPD_100); // R12
    assign speed_low_flag = (st_reg.speed != `MCRP_SPD_1G); // R12

    // checks beside the logic
    a_addr_width: assert property (@(posedge mclk) // R1
        $bits(s_axi_awaddr) == (AVB_EN ? 17 : 12) && $bits(s_axi_araddr) == $bits(s_axi_awaddr))
        else $error("bus address width wrong");
    a_write_answer: assert property (@(posedge mclk) disable iff (!core_rst_n) // R2
        s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> s_axi_bvalid && reg_wr)
        else $error("write not answered next cycle");
    a_read_hold: assert property (@(posedge mclk) disable iff (!core_rst_n || !s_axi_resetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) // R2
        else $error("read answer dropped early");
    a_bus_idle: assert property (@(posedge mclk) disable iff (!core_rst_n) // R2
        !s_axi_resetn |=> !s_axi_bvalid && !s_axi_rvalid && !reg_wr)
        else $error("bus not idle under local reset");
    a_rx_vector: assert property (@(posedge mclk) disable iff (!core_rst_n) // R3
        !MGMT_PRESENT && rx_rst_n |=> rx_cfg_out == $past(rx_mac_config_vector))
        else $error("receive vector not taken");
    a_tx_vector: assert property (@(posedge mclk) disable iff (!core_rst_n) // R4
        !MGMT_PRESENT && tx_rst_n |=> tx_cfg_out == $past(tx_mac_config_vector))
        else $error("transmit vector not taken");
    // a steady vector must give a steady output, whatever the vector did inside the cycle
    a_vector_flopped: assert property (@(posedge mclk) disable iff (!core_rst_n) // R5
        !MGMT_PRESENT && rx_rst_n && $past(rx_rst_n) && $past(core_rst_n)
            && $stable(rx_mac_config_vector) |=> $stable(rx_cfg_out))
        else $error("config output moved without a registered input");
    a_global_reset: assert property (@(posedge mclk) // R6
        !core_rst_n |-> !rx_reset && !tx_reset && !s_axi_bvalid && !tx_clk_en && rx_cfg_out == '0)
        else $error("global reset did not clear state");
    a_rx_only: assert property (@(posedge mclk) disable iff (!core_rst_n) // R7
        !rx_rst_n && tx_rst_n && !MGMT_PRESENT |=> rx_cfg_out == '0
            && tx_cfg_out == $past(tx_mac_config_vector))
        else $error("receive reset leaked into transmit side");
    a_sw_reset: assert property (@(posedge mclk) disable iff (!core_rst_n) // R8
        sw_tx_reset_req ##1 sw_tx_reset_req |-> tx_reset)
        else $error("transmit reset output not following request");
    a_tick_100: assert property (@(posedge mclk) disable iff (!core_rst_n || !tx_rst_n) // R9
        tx_clk_en && speed_100_flag ##1 speed_100_flag [*5]
            |-> tx_clk_en && !$past(tx_clk_en))
        else $error("100M enable spacing not five cycles");
    a_tick_10: assert property (@(posedge mclk) disable iff (!core_rst_n || !tx_rst_n) // R9
        tx_clk_en && st_reg.speed == 2'h0 |=> !tx_clk_en [*8])
        else $error("10M enable too frequent");
    a_speed_flag: assert property (@(posedge mclk) disable iff (!core_rst_n || !tx_rst_n) // R12
        1'b1 |=> speed_low_flag == (MGMT_PRESENT ? ($past(mgmt_speed) != `MCRP_SPD_1G)
            : ($past(tx_cfg_out[`MCRP_SPD_HI:`MCRP_SPD_LO]) != `MCRP_SPD_1G)))
        else $error("speed flag not following speed field");
    a_mgmt_wins: assert property (@(posedge mclk) disable iff (!core_rst_n || !tx_rst_n) // R13
        MGMT_PRESENT |=> tx_cfg_out == $past(mgmt_tx_cfg))
        else $error("vector used while management port present");
    c_write: cover property (@(posedge mclk) disable iff (!core_rst_n) wr_go ##1 s_axi_bvalid);
    c_read: cover property (@(posedge mclk) disable iff (!core_rst_n) rd_go ##1 s_axi_rvalid);
    c_slow: cover property (@(posedge mclk) disable iff (!core_rst_n)
        tx_clk_en && st_reg.speed == 2'h0);
    c_swrst: cover property (@(posedge mclk) disable iff (!core_rst_n) rx_reset && tx_reset);
endmodule : mcrp_front

// ---- tb/mcrp_bus_master.sv ----
// bus master model driving the configuration port
`timescale 1ns/1ns
module mcrp_bus_master (
    input  wire logic        mclk,
    output logic [11:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [11:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // bus idle from time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    end

    // write: hold request until both readies seen at an edge, then take response
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r, output bit ok);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do begin
            @(posedge mclk);
            n++;
        end while (!(s_axi_awready && s_axi_wready) && n < 20);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h1;
        // released lines show inverse so stale values never pass
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
        do begin
            @(posedge mclk);
            n++;
        end while (!s_axi_bvalid && n < 40);
        ok = (s_axi_bvalid === 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    // read: same holding discipline on the read channels
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r, output bit ok);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (!s_axi_arready && n < 20);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (!s_axi_rvalid && n < 40);
        ok = (s_axi_rvalid === 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : mcrp_bus_master

// ---- tb/tb_mac_config_clock_reset_port.sv ----
// testbench for the configuration, clock and reset front end
`timescale 1ns/1ns
module tb_mac_config_clock_reset_port;
    logic        mclk, rst_n, rx_rst_n, tx_rst_n, s_axi_resetn;
    logic        sw_rx_reset_req, sw_tx_reset_req, reg_wr, tx_clk_en;
    logic [11:0] s_axi_awaddr, s_axi_araddr, reg_waddr, reg_raddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, reg_wdata, reg_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, rx_reset, tx_reset;
    logic        speed_100_flag, speed_low_flag;
    logic [79:0] rx_mac_config_vector, tx_mac_config_vector, rx_cfg_out, tx_cfg_out;
    int          bad_count, check_count, wr_pulses;
    logic [1:0]  mgmt_speed;
    logic [79:0] mgmt_rx_cfg, mgmt_tx_cfg, rx_cfg_m, tx_cfg_m;
    logic        tx_clk_en_m, spd100_m, spdlow_m;

    // vectors drive configuration, so register contents are tied off
    mcrp_front #(.AVB_EN(1'b0), .MGMT_PRESENT(1'b0)) DUT (
        .mclk, .rst_n, .rx_rst_n, .tx_rst_n, .s_axi_resetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .reg_wr, .reg_waddr, .reg_wdata, .reg_raddr, .reg_rdata, .mgmt_speed(2'h0),
        .mgmt_rx_cfg(80'h0), .mgmt_tx_cfg(80'h0), .rx_mac_config_vector,
        .tx_mac_config_vector, .sw_rx_reset_req, .sw_tx_reset_req, .rx_cfg_out,
        .tx_cfg_out, .rx_reset, .tx_reset, .tx_clk_en, .speed_100_flag, .speed_low_flag);
    mcrp_bus_master mst (
        .mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    // second copy with the management port present; its bus stays idle
    mcrp_front #(.AVB_EN(1'b0), .MGMT_PRESENT(1'b1)) DUT_MGMT (
        .mclk, .rst_n, .rx_rst_n, .tx_rst_n, .s_axi_resetn, .s_axi_awaddr(12'h000),
        .s_axi_awvalid(1'b0), .s_axi_awready(), .s_axi_wdata(32'h0), .s_axi_wvalid(1'b0),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b0),
        .s_axi_araddr(12'h000), .s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b0), .reg_wr(), .reg_waddr(),
        .reg_wdata(), .reg_raddr(), .reg_rdata(32'h0), .mgmt_speed, .mgmt_rx_cfg,
        .mgmt_tx_cfg, .rx_mac_config_vector, .tx_mac_config_vector, .sw_rx_reset_req,
        .sw_tx_reset_req, .rx_cfg_out(rx_cfg_m), .tx_cfg_out(tx_cfg_m), .rx_reset(),
        .tx_reset(), .tx_clk_en(tx_clk_en_m), .speed_100_flag(spd100_m),
        .speed_low_flag(spdlow_m));

    // outside register map: read data derived from the address
    assign reg_rdata = {20'h5a5a0, reg_raddr};
    always #25 mclk = ~mclk;
    always @(posedge mclk) if (reg_wr === 1'b1) wr_pulses++;

    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // a hung handshake ends the run at once
    task automatic bus_ok(input bit ok);
        chk(ok, 1'b1);
        if (!ok) tally_and_finish();
    endtask : bus_ok

    // two writes then a read, one register strobe per write
    task automatic bus_test;
        bit ok;
        logic [1:0] r;
        logic [31:0] d;
        mst.wr(12'habc, 32'hdeadbeef, r, ok);
        bus_ok(ok);
        mst.wr(12'h004, 32'h01234567, r, ok);
        bus_ok(ok);
        @(negedge mclk);
        chk(r, 2'h0);
        chk(wr_pulses, 2);
        chk({reg_waddr, reg_wdata}, {12'h004, 32'h01234567});
        mst.rd(12'h123, d, r, ok);
        bus_ok(ok);
        chk({r, d}, {2'h0, 20'h5a5a0, 12'h123});
    endtask : bus_test

    // vectors are taken whole, one cycle after they change
    task automatic vector_test;
        @(posedge mclk);
        rx_mac_config_vector <= 80'h1234_5678_9abc_def0_1357;
        tx_mac_config_vector <= 80'hc0c4_0f0f_1e1e_2d2d_3c3c;
        repeat (3) @(negedge mclk);
        chk(rx_cfg_out, 80'h1234_5678_9abc_def0_1357);
        chk(tx_cfg_out, 80'hc0c4_0f0f_1e1e_2d2d_3c3c);
    endtask : vector_test

    // each speed: flags and transmit enable rate over 100 reference cycles
    task automatic speed_test;
        // the spare code 3 runs the slow divider; it is visited before 10M on purpose
        logic [1:0] code[4] = '{2'h2, 2'h1, 2'h3, 2'h0};
        logic [1:0] fl[4] = '{2'b00, 2'b11, 2'b01, 2'b01};
        int dv[4] = '{1, 5, 50, 50};
        int n;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            tx_mac_config_vector[66:65] <= code[i];
            repeat (4) @(posedge mclk);
            n = 0;
            repeat (100) begin
                @(negedge mclk);
                if (tx_clk_en === 1'b1) n++;
            end
            chk(n, 100 / dv[i]);
            chk({speed_100_flag, speed_low_flag}, fl[i]);
        end
    endtask : speed_test

    // management contents win over the vectors, which hold other values meanwhile
    task automatic mgmt_test;
        int n;
        @(posedge mclk);
        mgmt_rx_cfg <= 80'h0f1e_2d3c_4b5a_6978_8796;
        mgmt_tx_cfg <= 80'ha5a5_5a5a_a5a5_5a5a_a5a5;
        mgmt_speed  <= 2'h1;
        repeat (4) @(posedge mclk);
        n = 0;
        repeat (100) begin
            @(negedge mclk);
            if (tx_clk_en_m === 1'b1) n++;
        end
        chk(rx_cfg_m, 80'h0f1e_2d3c_4b5a_6978_8796);
        chk(tx_cfg_m, 80'ha5a5_5a5a_a5a5_5a5a_a5a5);
        chk({spd100_m, spdlow_m}, 2'b11);
        chk(n, 20);
    endtask : mgmt_test

    // software resets, domain resets, then global asynchronous reset
    task automatic reset_test;
        @(posedge mclk);
        sw_rx_reset_req <= 1'b1;
        repeat (2) @(negedge mclk);
        chk({rx_reset, tx_reset}, 2'b10);
        @(posedge mclk);
        {sw_rx_reset_req, sw_tx_reset_req} <= 2'b01;
        repeat (2) @(negedge mclk);
        chk({rx_reset, tx_reset}, 2'b01);
        @(posedge mclk);
        {sw_tx_reset_req, rx_rst_n} <= 2'b00;
        repeat (2) @(negedge mclk);
        chk(rx_cfg_out, 80'h0);
        chk(tx_cfg_out, tx_mac_config_vector);
        @(posedge mclk);
        {rx_rst_n, tx_rst_n} <= 2'b10;
        repeat (3) @(negedge mclk);
        chk(tx_cfg_out, 80'h0);
        chk(rx_cfg_out, rx_mac_config_vector);
        @(posedge mclk);
        {tx_rst_n, rst_n} <= 2'b10;
        #1;
        chk(rx_cfg_out, 80'h0);
        chk(tx_cfg_out, 80'h0);
        @(posedge mclk);
        rst_n <= 1'b1;
    endtask : reset_test

    initial begin
        mclk = 1'b0;
        {rst_n, rx_rst_n, tx_rst_n, s_axi_resetn} = 4'h7;
        {sw_rx_reset_req, sw_tx_reset_req} = 2'h0;
        rx_mac_config_vector = 80'h0;
        tx_mac_config_vector = 80'h0;
        mgmt_speed = 2'h2;
        {mgmt_rx_cfg, mgmt_tx_cfg} = 160'h0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        bus_test();
        vector_test();
        mgmt_test();
        speed_test();
        reset_test();
        tally_and_finish();
    end

    // overall limit on run time
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish();
    end
endmodule : tb_mac_config_clock_reset_port
